// ==== config_word_field_decode.sv ====
// What this block does
// - Prescale bit picks divide 128 or 32
// - Postscale ratio is two to code
// - Wait enable holds PLL switch until lock
// - Wait disabled: switch completes without lock
// - I2C select high picks primary pins
// - Debug code 11,10,01 pick pairs one-three
// - Owner one: PWM pins port-controlled, port sets output enables
// - Owner zero: PWM drives pins as outputs
// - High-side polarity one means active high
// - Low-side polarity one means active high
// - Prescaler divides 32 kHz oscillator ticks
//
// Added by the designer: the placing of the registers and the address-and-strobe port.
`timescale 1ns/10ps
`default_nettype none
module config_word_field_decode (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        arst_n,
  // Configuration memory
  input  wire logic [15:0] cfgWord,
  // Low-power oscillator tick, one cycle per oscillator period
  input  wire logic        oscTick,
  input  wire logic        wdtClear,
  // Clock switch
  input  wire logic        switchReq,
  input  wire logic        switchToPll,
  input  wire logic        pllLocked,
  // Raw PWM drive from the PWM engine, then port output and enables
  input  wire logic [2:0]  pwmHighRaw,
  input  wire logic [2:0]  pwmLowRaw,
  input  wire logic [5:0]  portOut,
  input  wire logic [5:0]  portOe,
  // Register port
  input  wire logic [3:0]  regAddr,
  input  wire logic [31:0] regWdata,
  input  wire logic        regWr,
  input  wire logic        regRd,
  output logic      [31:0] regRdata,
  // Decoded settings
  output cfg_decode_pkg::cfg_t cfgOut,
  output logic             wdtTimeout,
  output logic             switchDone,
  output logic             i2cOnPrimary,
  output logic             i2cOnAlternate,
  output logic [2:0]       debugPairEn,
  output logic             debugCodeBad,
  output logic [5:0]       pwmPinOut,
  output logic [5:0]       pwmPinOe
);

  // ----------------------------------------------------------------
  // Capture of the configuration word
  // ----------------------------------------------------------------
  cfg_decode_pkg::cfg_t cfg_q;
  logic                 loaded_q;

  // Taken once on the first edge after reset release, then frozen so a
  // glitch on the memory bus cannot shift a running setting
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cfg_q    <= cfg_decode_pkg::CFG_RESET[11:0];
      loaded_q <= 1'b0;
    end else if (!loaded_q) begin
      cfg_q    <= cfgWord[11:0];
      loaded_q <= 1'b1;
    end
  end

  assign cfgOut = cfg_q;

  // ----------------------------------------------------------------
  // Watchdog prescaler and postscaler
  // ----------------------------------------------------------------
  logic [21:0] preLimit;
  logic [21:0] postLimit;
  logic        preTick;
  logic        postTick;
  logic        wdtClr;

  // Prescale limit is ratio minus one
  assign preLimit = cfg_q.wdtPrescaleSelect
                  ? 22'(cfg_decode_pkg::PRE_LARGE - 1)
                  : 22'(cfg_decode_pkg::PRE_SMALL - 1);
  // Postscale ratio is 2**code, so limit is that minus one
  assign postLimit = (22'h1 << cfg_q.wdtPostscaleSelect) - 22'h1;
  // Counts restart on a clear or a completed clock switch
  assign wdtClr = wdtClear | switchDone | !loaded_q;

  wdt_divider #(.WIDTH(22)) uPre (
    .clk    (clk),
    .arst_n (arst_n),
    .tickIn (oscTick),
    .clear  (wdtClr),
    .limit  (preLimit),
    .tickOut(preTick)
  );

  wdt_divider #(.WIDTH(22)) uPost (
    .clk    (clk),
    .arst_n (arst_n),
    .tickIn (preTick),
    .clear  (wdtClr),
    .limit  (postLimit),
    .tickOut(postTick)
  );

  // Timeout is sticky until cleared; a new tick wins over the clear
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      wdtTimeout <= 1'b0;
    end else if (postTick) begin
      wdtTimeout <= 1'b1;
    end else if (wdtClear) begin
      wdtTimeout <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Clock switch sequencing
  // ----------------------------------------------------------------
  cfg_decode_pkg::sw_state_t swState_q;

  // A switch toward the PLL may stall for lock; others finish at once
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      swState_q <= cfg_decode_pkg::SW_IDLE;
    end else begin
      unique case (swState_q)
        cfg_decode_pkg::SW_IDLE: begin
          if (switchReq && loaded_q) begin
            if (switchToPll && cfg_q.pllLockWaitEnable && !pllLocked)
              swState_q <= cfg_decode_pkg::SW_WAIT_LOCK;
            else
              swState_q <= cfg_decode_pkg::SW_DONE;
          end
        end
        cfg_decode_pkg::SW_WAIT_LOCK: begin
          if (pllLocked)
            swState_q <= cfg_decode_pkg::SW_DONE;
        end
        cfg_decode_pkg::SW_DONE: begin
          swState_q <= cfg_decode_pkg::SW_IDLE;
        end
        default: swState_q <= cfg_decode_pkg::SW_IDLE;
      endcase
    end
  end

  assign switchDone = (swState_q == cfg_decode_pkg::SW_DONE);

  // ----------------------------------------------------------------
  // Pin routing
  // ----------------------------------------------------------------
  // I2C pin pair choice
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      i2cOnPrimary   <= 1'b0;
      i2cOnAlternate <= 1'b0;
    end else begin
      i2cOnPrimary   <= loaded_q & cfg_q.i2cAlternatePinSelect;
      i2cOnAlternate <= loaded_q & !cfg_q.i2cAlternatePinSelect;
    end
  end

  // Debug pair one-hot; reserved code enables nothing and is flagged,
  // since the programmer is trusted never to write it
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      debugPairEn  <= 3'h0;
      debugCodeBad <= 1'b0;
    end else begin
      debugPairEn  <= 3'h0;
      debugCodeBad <= 1'b0;
      if (loaded_q) begin
        unique case (cfg_q.debugChannelSelect)
          cfg_decode_pkg::DBG_PAIR1:    debugPairEn <= 3'h1;
          cfg_decode_pkg::DBG_PAIR2:    debugPairEn <= 3'h2;
          cfg_decode_pkg::DBG_PAIR3:    debugPairEn <= 3'h4;
          cfg_decode_pkg::DBG_RESERVED: debugCodeBad <= 1'b1;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // PWM pin ownership and polarity
  // ----------------------------------------------------------------
  logic [5:0] pwmActive;
  logic [5:0] polInvert;

  // Active-high keeps raw level, active-low inverts it
  assign pwmActive = {pwmHighRaw, pwmLowRaw};
  assign polInvert = {{3{!cfg_q.highSidePolarity}},
                      {3{!cfg_q.lowSidePolarity}}};

  // Pins sit tristated during reset and until the word is taken; then the owner bit decides
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      pwmPinOut <= 6'h00;
      pwmPinOe  <= 6'h00;
    end else if (!loaded_q) begin
      pwmPinOut <= 6'h00;
      pwmPinOe  <= 6'h00;
    end else if (cfg_q.pwmPinResetOwner) begin
      pwmPinOut <= portOut;
      pwmPinOe  <= portOe;
    end else begin
      pwmPinOut <= pwmActive ^ polInvert;
      pwmPinOe  <= 6'h3f;
    end
  end

  // ----------------------------------------------------------------
  // Register port
  // ----------------------------------------------------------------
  logic [15:0] lockWaitCnt_q;

  // Cycles spent waiting for PLL lock, saturating; a write to ADDR_LCNT clears it except during the wait
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      lockWaitCnt_q <= 16'h0000;
    end else if (swState_q == cfg_decode_pkg::SW_WAIT_LOCK) begin
      if (lockWaitCnt_q != 16'hffff)
        lockWaitCnt_q <= lockWaitCnt_q + 16'h0001;
    end else if (regWr && regAddr == cfg_decode_pkg::ADDR_LCNT) begin
      lockWaitCnt_q <= 16'h0000;
    end
  end

  // Read data valid the cycle after the strobe only; unmapped reads zero
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      regRdata <= 32'h0000_0000;
    end else begin
      regRdata <= 32'h0000_0000;
      if (regRd) begin
        unique case (regAddr)
          cfg_decode_pkg::ADDR_CFG:  regRdata <= {20'h00000, cfg_q};
          cfg_decode_pkg::ADDR_STAT: regRdata <= {25'h0000000,
              debugCodeBad, wdtTimeout, i2cOnPrimary, swState_q,
              pllLocked, loaded_q};
          cfg_decode_pkg::ADDR_LCNT: regRdata <= {16'h0000, lockWaitCnt_q};
          default:                   regRdata <= 32'h0000_0000;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  property p_prescale;
    @(posedge clk) disable iff (!arst_n)
      loaded_q |-> preLimit == (cfg_q.wdtPrescaleSelect ? 22'h7f : 22'h1f);
  endproperty
  a_prescale: assert property (p_prescale)
    else $error("prescale limit wrong");

  property p_postscale;
    @(posedge clk) disable iff (!arst_n)
      (cfg_q.wdtPostscaleSelect == 4'hf) |-> postLimit == 22'h7fff;
  endproperty
  a_postscale: assert property (p_postscale)
    else $error("postscale limit wrong");

  property p_lock_wait;
    @(posedge clk) disable iff (!arst_n)
      (swState_q == cfg_decode_pkg::SW_WAIT_LOCK && !pllLocked)
        |=> !switchDone;
  endproperty
  a_lock_wait: assert property (p_lock_wait)
    else $error("switch finished without lock");

  property p_no_wait;
    @(posedge clk) disable iff (!arst_n)
      (swState_q == cfg_decode_pkg::SW_IDLE && switchReq && loaded_q &&
       !cfg_q.pllLockWaitEnable) |=> switchDone;
  endproperty
  a_no_wait: assert property (p_no_wait)
    else $error("switch stalled with wait disabled");

  property p_i2c;
    @(posedge clk) disable iff (!arst_n)
      loaded_q ##1 1'b1 |-> i2cOnPrimary == $past(cfg_q.i2cAlternatePinSelect)
                            && i2cOnAlternate != i2cOnPrimary;
  endproperty
  a_i2c: assert property (p_i2c)
    else $error("i2c routing wrong");

  property p_debug;
    @(posedge clk) disable iff (!arst_n)
      $past(loaded_q) && $past(cfg_q.debugChannelSelect) == 2'h3
        |-> debugPairEn == 3'h1;
  endproperty
  a_debug: assert property (p_debug)
    else $error("debug pair one not chosen");

  property p_pwm_port;
    @(posedge clk) disable iff (!arst_n)
      $past(loaded_q) && $past(cfg_q.pwmPinResetOwner)
        |-> pwmPinOe == $past(portOe);
  endproperty
  a_pwm_port: assert property (p_pwm_port)
    else $error("port does not own pins");

  property p_pwm_drive;
    @(posedge clk) disable iff (!arst_n)
      $past(loaded_q) && !$past(cfg_q.pwmPinResetOwner)
        |-> pwmPinOe == 6'h3f
            && pwmPinOut[5] == ($past(pwmHighRaw[2]) ~^
                                $past(cfg_q.highSidePolarity))
            && pwmPinOut[0] == ($past(pwmLowRaw[0]) ~^
                                $past(cfg_q.lowSidePolarity));
  endproperty
  a_pwm_drive: assert property (p_pwm_drive)
    else $error("pwm drive or polarity wrong");

  // Whole high-side group follows its polarity bit, not just one pin
  property p_high_pol;
    @(posedge clk) disable iff (!arst_n)
      $past(loaded_q) && !$past(cfg_q.pwmPinResetOwner)
        |-> pwmPinOut[5:3] == ($past(cfg_q.highSidePolarity)
                               ? $past(pwmHighRaw) : ~$past(pwmHighRaw));
  endproperty
  a_high_pol: assert property (p_high_pol)
    else $error("high side polarity wrong");

  // Low side is judged apart so a swapped polarity bit shows up
  property p_low_pol;
    @(posedge clk) disable iff (!arst_n)
      $past(loaded_q) && !$past(cfg_q.pwmPinResetOwner)
        |-> pwmPinOut[2:0] == ($past(cfg_q.lowSidePolarity)
                               ? $past(pwmLowRaw) : ~$past(pwmLowRaw));
  endproperty
  a_low_pol: assert property (p_low_pol)
    else $error("low side polarity wrong");

  property p_hold;
    @(posedge clk) disable iff (!arst_n)
      loaded_q |=> $stable(cfg_q);
  endproperty
  a_hold: assert property (p_hold)
    else $error("settings changed while running");

  c_wait: cover property (@(posedge clk) disable iff (!arst_n)
    swState_q == cfg_decode_pkg::SW_WAIT_LOCK ##1 switchDone);
  c_timeout: cover property (@(posedge clk) disable iff (!arst_n)
    $rose(wdtTimeout));
  c_reserved: cover property (@(posedge clk) disable iff (!arst_n)
    debugCodeBad);

endmodule
`default_nettype wire

// ==== cfg_decode_pkg.sv ====
package cfg_decode_pkg;

  // ----------------------------------------------------------------
  // Configuration word layout
  // ----------------------------------------------------------------
  localparam int CFG_WIDTH          = 16;
  localparam int POS_POST           = 0;   // 4-bit postscale code
  localparam int POS_PRE            = 4;
  localparam int POS_PLLWAIT        = 5;
  localparam int POS_I2CSEL         = 6;
  localparam int POS_DBG            = 7;   // 2-bit debug channel
  localparam int POS_PWMOWN         = 9;
  localparam int POS_HIGH_POL       = 10;
  localparam int POS_LOW_POL        = 11;
  localparam logic [15:0] CFG_RESET = 16'hffff;

  // ----------------------------------------------------------------
  // Watchdog and register map
  // ----------------------------------------------------------------
  localparam int  PRE_SMALL         = 32;
  localparam int  PRE_LARGE         = 128;
  localparam int  POST_CODE_MAX     = 15;
  localparam int  OSC_HZ            = 32000;
  localparam int  BASE_MS_SMALL     = 1;
  localparam int  BASE_MS_LARGE     = 4;
  localparam logic [3:0] ADDR_CFG   = 4'h0;
  localparam logic [3:0] ADDR_STAT  = 4'h4;
  localparam logic [3:0] ADDR_LCNT  = 4'h8;

  typedef enum logic [1:0] {
    DBG_RESERVED = 2'h0,
    DBG_PAIR3    = 2'h1,
    DBG_PAIR2    = 2'h2,
    DBG_PAIR1    = 2'h3
  } dbg_sel_t;

  typedef struct packed {
    logic        lowSidePolarity;
    logic        highSidePolarity;
    logic        pwmPinResetOwner;
    dbg_sel_t    debugChannelSelect;
    logic        i2cAlternatePinSelect;
    logic        pllLockWaitEnable;
    logic        wdtPrescaleSelect;
    logic [3:0]  wdtPostscaleSelect;
  } cfg_t;

  typedef enum logic [1:0] {
    SW_IDLE,
    SW_WAIT_LOCK,
    SW_DONE
  } sw_state_t;

endpackage

// ==== wdt_divider.sv ====
`timescale 1ns/10ps
`default_nettype none
module wdt_divider #(
  parameter int WIDTH = 22
) (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             arst_n,
  // Control
  input  wire logic             tickIn,
  input  wire logic             clear,
  input  wire logic [WIDTH-1:0] limit,
  // Result
  output logic                  tickOut
);

  // Elaboration check: a one-bit count cannot hold a useful limit
  if (WIDTH < 2) begin : gWidthCheck
    $error("wdt_divider width too small");
  end

  logic [WIDTH-1:0] count_q;

  // Counts input ticks; one output tick each limit+1 input ticks
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      count_q <= '0;
      tickOut <= 1'b0;
    end else if (clear) begin
      count_q <= '0;
      tickOut <= 1'b0;
    end else begin
      tickOut <= 1'b0;
      if (tickIn) begin
        if (count_q >= limit) begin
          count_q <= '0;
          tickOut <= 1'b1;
        end else begin
          count_q <= count_q + 1'b1;
        end
      end
    end
  end

endmodule
`default_nettype wire

// ==== cfg_memory_model.sv ====
`timescale 1ns/10ps
`default_nettype none
module cfg_memory_model (
  // Clock
  input  wire logic        clk,
  // Programming side
  input  wire logic        progEn,
  input  wire logic [15:0] progWord,
  input  wire logic        allowReserved,
  // Stored configuration word
  output logic      [15:0] cfgWord
);
  // ----------------------------------------------
  // Nonvolatile cell, erased state is all ones
  // ----------------------------------------------
  initial cfgWord = 16'hffff;

  // Reserved debug code is refused unless a test forces it in
  always @(posedge clk) begin
    if (progEn && (progWord[8:7] != 2'h0 || allowReserved)) begin
      cfgWord <= progWord;
    end
  end
endmodule
`default_nettype wire

// ==== tb_top.sv ====
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  // ----------------------------------------------
  // Signals
  // ----------------------------------------------
  logic                 clk, arst_n, progEn, allowReserved, hit;
  logic [15:0]          progWord, cfgWord;
  logic                 oscTick, wdtClear, switchReq, switchToPll;
  logic                 pllLocked, regWr, regRd, wdtTimeout, switchDone;
  logic                 i2cOnPrimary, i2cOnAlternate, debugCodeBad;
  logic [2:0]           pwmHighRaw, pwmLowRaw, debugPairEn;
  logic [5:0]           portOut, portOe, pwmPinOut, pwmPinOe;
  logic [3:0]           regAddr;
  logic [31:0]          regWdata, regRdata, rd;
  cfg_decode_pkg::cfg_t cfgOut;
  int                   numErrors, checks;

  cfg_memory_model mem (.clk(clk), .progEn(progEn), .progWord(progWord),
    .allowReserved(allowReserved), .cfgWord(cfgWord));

  config_word_field_decode dut (.clk(clk), .arst_n(arst_n),
    .cfgWord(cfgWord), .oscTick(oscTick), .wdtClear(wdtClear),
    .switchReq(switchReq), .switchToPll(switchToPll),
    .pllLocked(pllLocked), .pwmHighRaw(pwmHighRaw),
    .pwmLowRaw(pwmLowRaw), .portOut(portOut), .portOe(portOe),
    .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr),
    .regRd(regRd), .regRdata(regRdata), .cfgOut(cfgOut),
    .wdtTimeout(wdtTimeout), .switchDone(switchDone),
    .i2cOnPrimary(i2cOnPrimary), .i2cOnAlternate(i2cOnAlternate),
    .debugPairEn(debugPairEn), .debugCodeBad(debugCodeBad),
    .pwmPinOut(pwmPinOut), .pwmPinOe(pwmPinOe));

  // 40 MHz clock
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  // ----------------------------------------------
  // Helpers
  // ----------------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      numErrors++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic endSim;
    $display("comparisons %0d mismatches %0d", checks, numErrors);
    if (numErrors == 0 && checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // Called at an edge; samples first so a one-cycle pulse is not missed
  task automatic waitFor(input int n, input logic onWdt, input logic must);
    hit = 1'b0;
    for (int i = 0; i < n && !hit; i++) begin
      #1;
      hit = onWdt ? wdtTimeout : switchDone;
      if (!hit) @(posedge clk);
    end
    if (must && hit !== 1'b1) begin
      numErrors++;
      endSim();
    end
  endtask

  // Program the word, then reset so the device takes it
  task automatic boot(input logic [15:0] w);
    @(posedge clk);
    progWord <= w;
    progEn <= 1'b1;
    allowReserved <= (w[8:7] == 2'h0);
    pllLocked <= 1'b0;
    @(posedge clk);
    progEn <= 1'b0;
    arst_n <= 1'b0;
    repeat (2) @(posedge clk);
    arst_n <= 1'b1;
    repeat (2) @(posedge clk);
    #1;
  endtask

  task automatic regRead(input logic [3:0] a);
    @(posedge clk);
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge clk);
    regRd <= 1'b0;
    #1;
    rd = regRdata;
  endtask

  task automatic request(input logic toPll);
    @(posedge clk);
    switchToPll <= toPll;
    switchReq <= 1'b1;
    @(posedge clk);
    switchReq <= 1'b0;
  endtask

  // Oscillator ticks spaced two cycles apart
  task automatic ticks(input int n);
    repeat (n) begin
      @(posedge clk);
      oscTick <= 1'b1;
      @(posedge clk);
      oscTick <= 1'b0;
    end
  endtask

  // ----------------------------------------------
  // Scenarios
  // ----------------------------------------------
  task automatic testDecode;
    logic [15:0] w;
    logic [2:0]  pair;
    logic [5:0]  pin;
    logic [15:0] words [4] = '{16'h05c0, 16'h0900, 16'h02c0, 16'h0c00};
    for (int k = 0; k < 4; k++) begin
      w = words[k];
      boot(w);
      pair = (w[8:7] == 2'h0) ? 3'h0 : 3'h1 << (2'h3 - w[8:7]);
      pin = w[9] ? portOut
                 : {pwmHighRaw ^ {3{~w[10]}}, pwmLowRaw ^ {3{~w[11]}}};
      check(cfgOut, w[11:0]);
      check(i2cOnPrimary, w[6]);
      check(i2cOnAlternate, !w[6]);
      check(debugPairEn, pair);
      check(debugCodeBad, w[8:7] == 2'h0);
      check(pwmPinOut, pin);
      check(pwmPinOe, w[9] ? portOe : 6'h3f);
      regRead(4'h0);
      check(rd, {20'h0, w[11:0]});
      regRead(4'h4);
      check(rd, {25'h0, w[8:7] == 2'h0, 1'b0, w[6], 4'h1});
    end
    $display("decode test done");
  endtask

  // Reprogramming and register writes must not disturb running settings
  task automatic testHold;
    boot(16'h05c0);
    @(posedge clk);
    progWord <= 16'h0900;
    progEn <= 1'b1;
    @(posedge clk);
    progEn <= 1'b0;
    regAddr <= 4'h0;
    regWdata <= 32'h0;
    regWr <= 1'b1;
    @(posedge clk);
    regWr <= 1'b0;
    regRead(4'h0);
    check(rd, 32'h0000_05c0);
    check(cfgOut, 12'h5c0);
    check(debugPairEn, 3'h1);
    $display("hold test done");
  endtask

  task automatic testSwitch;
    boot(16'h05e0);
    request(1'b1);
    waitFor(20, 1'b0, 1'b0);
    check(hit, 1'b0);
    pllLocked <= 1'b1;
    waitFor(3, 1'b0, 1'b1);
    // Twenty idle waits plus the edge that sees lock
    regRead(4'h8);
    check(rd, 32'h0000_0015);
    boot(16'h05c0);
    request(1'b1);
    waitFor(1, 1'b0, 1'b1);
    check(hit, 1'b1);
    $display("switch test done");
  endtask

  // Longest postscale code would need millions of cycles, so small ones
  task automatic testWdt;
    logic [15:0] cfgs [3] = '{16'h05c1, 16'h05d0, 16'h05c0};
    int          counts [3] = '{64, 128, 32};
    for (int k = 0; k < 3; k++) begin
      boot(cfgs[k]);
      @(posedge clk);
      wdtClear <= 1'b1;
      @(posedge clk);
      wdtClear <= 1'b0;
      ticks(counts[k] - 1);
      waitFor(6, 1'b1, 1'b0);
      check(hit, 1'b0);
      ticks(1);
      waitFor(5, 1'b1, 1'b1);
      check(hit, 1'b1);
      // Sticky flag must drop on a clear with no tick beside it
      @(posedge clk);
      wdtClear <= 1'b1;
      @(posedge clk);
      wdtClear <= 1'b0;
      #1;
      check(wdtTimeout, 1'b0);
    end
    $display("watchdog test done");
  endtask

  // ----------------------------------------------
  // Main sequence
  // ----------------------------------------------
  initial begin
    arst_n = 1'b0;
    progEn = 1'b0;
    allowReserved = 1'b0;
    progWord = 16'hffff;
    oscTick = 1'b0;
    wdtClear = 1'b0;
    switchReq = 1'b0;
    switchToPll = 1'b0;
    pllLocked = 1'b0;
    pwmHighRaw = 3'h5;
    pwmLowRaw = 3'h3;
    portOut = 6'h2a;
    portOe = 6'h15;
    regAddr = 4'h0;
    regWdata = 32'h0;
    regWr = 1'b0;
    regRd = 1'b0;
    numErrors = 0;
    checks = 0;
    repeat (10) @(posedge clk);
    arst_n <= 1'b1;
    testDecode();
    testHold();
    testSwitch();
    testWdt();
    endSim();
  end
endmodule
`default_nettype wire
